// >>> src/flash_dev.sv
// flash_dev.sv: device end, power-down, release, id and wrap read commands
// assumes: link pins come from another domain; array read answers combinationally
`timescale 1ns/10ps
`include "flash_cfg.svh"
module flash_dev import flash_pkg::*; #(
  parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_ID = 8'h17, // arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF, // arbitrary value
  parameter int PD_ENTRY_CYC = `NS2CYC_DN(`PD_ENTRY_NS),
  parameter int RELEASE_CYC = `NS2CYC_DN(`RELEASE_NS),
  parameter int RELEASE_ID_CYC = `NS2CYC_DN(`RELEASE_ID_NS)
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // serial link
  flash_link_if.dev link,
  // mode and array status
  input wire logic quad_command_mode,
  input wire logic busy,
  // array read port
  output logic [23:0] rd_addr,
  input wire logic [7:0] rd_data,
  // power state
  output logic powered_down
);

  // ****************************************
  // parameters and checks
  // ****************************************
  localparam int WAIT_W = 16; // wait counter width

  // counters must fit and never be zero
  if (PD_ENTRY_CYC < 1 || PD_ENTRY_CYC >= 2 ** WAIT_W ||
      RELEASE_CYC < 1 || RELEASE_CYC >= 2 ** WAIT_W ||
      RELEASE_ID_CYC < 1 || RELEASE_ID_CYC >= 2 ** WAIT_W) begin : g_bad
    $error("flash_dev wait count out of range");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic sclk_m; // first sync stage
    logic sclk_s; // second sync stage
    logic sclk_p; // previous synced clock
    logic cs_m; // first sync stage
    logic cs_s; // synced chip select
    logic [3:0] io_m; // first sync stage
    logic [3:0] io_s; // synced lines
    dev_state_e st; // frame progress
    logic [5:0] cnt; // bits in command, clocks in header
    logic [7:0] op; // decoded instruction
    logic [31:0] sr; // input shifter
    logic [23:0] addr; // read or id address
    logic [7:0] prm; // read parameters
    logic [7:0] osr; // output shifter
    logic [3:0] obits; // bits left in osr
    logic drv; // output lines enabled
    logic [2:0] bidx; // byte index of answer
    logic pd; // powered down
    logic rel; // frame releases from power-down
    wait_e wt; // timed wait kind
    logic [WAIT_W-1:0] wcnt; // timed wait count
  } dev_s;

  dev_s s; // current
  dev_s n; // next

  // ****************************************
  // functions
  // ****************************************
  // log2 of lines per clock for an instruction
  function automatic logic [1:0] lw_of(input logic [7:0] op, input logic quad);
    if (quad) return 2'h2;
    if (op == `OP_ID_DUAL) return 2'h1;
    if (op == `OP_ID_QUAD) return 2'h2;
    return 2'h0;
  endfunction : lw_of

  // shift lines into the input shifter
  function automatic logic [31:0] shin(input logic [31:0] sr, input logic [3:0] io,
                                       input logic [1:0] lw);
    unique case (lw)
      2'h0: return {sr[30:0], io[0]};
      2'h1: return {sr[29:0], io[1:0]};
      default: return {sr[27:0], io[3:0]};
    endcase
  endfunction : shin

  // header bits shifted in after the instruction
  function automatic logic [5:0] hdr_bits(input logic [7:0] op);
    unique case (op)
      `OP_ID_DUAL, `OP_ID_QUAD: return `HDR_ADDR_MODE;
      `OP_UNIQUE: return `HDR_UNIQUE;
      `OP_RELEASE: return `HDR_RELEASE;
      `OP_SET_PARAMS: return `HDR_PRM;
      default: return `HDR_ADDR;
    endcase
  endfunction : hdr_bits

  // next address inside the wrap section
  function automatic logic [23:0] wrap_next(input logic [23:0] a, input logic [1:0] wl);
    logic [23:0] mask;
    mask = (`WRAP_BASE << wl) - 24'h000001;
    return (a & ~mask) | ((a + 24'h000001) & mask);
  endfunction : wrap_next

  // ****************************************
  // next state
  // ****************************************
  logic rise; // synced sclk rising
  logic fall; // synced sclk falling
  logic [1:0] lw; // lanes of current instruction
  logic [3:0] w; // bits per clock
  logic [5:0] shclk; // header clocks that shift
  logic [5:0] total; // header plus dummy clocks
  logic [63:0] uid_sh; // unique id aligned to byte

  always_comb begin
    n = s;
    uid_sh = UNIQUE_ID << {s.bidx, 3'h0};
    rise = s.sclk_s & ~s.sclk_p;
    fall = ~s.sclk_s & s.sclk_p;
    lw = lw_of(s.op, quad_command_mode);
    w = 4'h1 << lw;
    shclk = hdr_bits(s.op) >> lw;
    total = shclk;
    if (s.op == `OP_ID_QUAD) total = shclk + `ID_QUAD_DUMMY;
    if (s.op == `OP_BURST_WRAP) begin
      // dummy count from last parameter byte
      total = shclk + `DUMMY_STEP * (6'h01 + 6'(s.prm[`PRM_DUMMY_LSB +: 2]));
    end
    // two-stage synchronisers
    n.sclk_m = link.sclk;
    n.sclk_s = s.sclk_m;
    n.sclk_p = s.sclk_s;
    n.cs_m = link.cs_n;
    n.cs_s = s.cs_m;
    n.io_m = link.io;
    n.io_s = s.io_m;

    // timed waits run regardless of frames
    if (s.wt != W_NONE) begin
      n.wcnt = s.wcnt - WAIT_W'(1);
      if (s.wcnt == WAIT_W'(1)) begin
        n.wt = W_NONE;
        n.pd = (s.wt == W_ENTRY);
      end
    end

    if (s.cs_s) begin
      // frame over or idle: act on what was armed
      if (s.st == D_ARM_PD) begin
        n.wt = W_ENTRY;
        n.wcnt = WAIT_W'(PD_ENTRY_CYC);
      end else if (s.rel && s.st != D_IDLE) begin
        n.wt = W_REL;
        // id readout takes the second release time
        n.wcnt = (s.st == D_OUT) ? WAIT_W'(RELEASE_ID_CYC) : WAIT_W'(RELEASE_CYC);
      end
      n.st = D_IDLE;
      n.drv = 1'b0;
      n.rel = 1'b0;
    end else begin
      unique case (s.st)
        // chip select just fell
        D_IDLE: begin
          n.st = D_CMD;
          n.cnt = '0;
          n.bidx = '0;
          n.obits = '0;
        end
        // instruction bits on rising edges
        D_CMD: if (rise) begin
          n.sr = shin(s.sr, s.io_s, quad_command_mode ? 2'h2 : 2'h0);
          n.cnt = s.cnt + (quad_command_mode ? 6'h04 : 6'h01);
          if (n.cnt == `CMD_BITS) begin
            n.op = n.sr[7:0];
            n.cnt = '0;
            if (s.wt != W_NONE) begin
              n.st = D_SKIP; // no instruction during entry or release wait
            end else if (s.pd) begin
              // only an idle release leaves power-down
              n.st = (n.op == `OP_RELEASE && !busy) ? D_HDR : D_SKIP;
              n.rel = (n.op == `OP_RELEASE && !busy);
            end else if (n.op == `OP_RELEASE && busy) begin
              n.st = D_SKIP;
            end else begin
              unique case (n.op)
                `OP_POWER_DOWN: n.st = D_ARM_PD;
                `OP_SET_PARAMS, `OP_BURST_WRAP: n.st = quad_command_mode ? D_HDR : D_SKIP;
                `OP_RELEASE, `OP_ID_SINGLE, `OP_ID_DUAL, `OP_ID_QUAD, `OP_UNIQUE: n.st = D_HDR;
                default: n.st = D_SKIP; // other commands belong elsewhere
              endcase
            end
          end
        end
        // any clock after bit eight cancels power-down
        D_ARM_PD: if (rise) n.st = D_SKIP;
        // address, mode and dummy clocks
        D_HDR: if (rise) begin
          if (s.cnt < shclk) n.sr = shin(s.sr, s.io_s, lw);
          n.cnt = s.cnt + 6'h01;
          if (n.cnt == total) begin
            n.addr = (hdr_bits(s.op) == `HDR_ADDR_MODE) ? n.sr[31:8] : n.sr[23:0];
            if (s.op == `OP_SET_PARAMS) begin
              n.prm = n.sr[7:0];
              n.st = D_SKIP;
            end else begin
              n.st = D_OUT;
            end
          end
        end
        // answer on falling edges, msb first
        D_OUT: if (fall) begin
          n.drv = 1'b1;
          if (s.obits == 4'h0) begin
            n.bidx = s.bidx + 3'h1;
            n.obits = `BYTE_BITS - w;
            unique case (s.op)
              `OP_RELEASE: n.osr = DEV_ID;
              `OP_UNIQUE: n.osr = uid_sh[63:56];
              `OP_BURST_WRAP: begin
                n.osr = rd_data;
                n.addr = wrap_next(s.addr, s.prm[`PRM_WRAP_LSB +: 2]);
              end
              // alternate codes, start chosen by address bit 0
              default: n.osr = (s.bidx[0] ^ s.addr[0]) ? DEV_ID : MFR_ID;
            endcase
          end else begin
            n.osr = s.osr << w;
            n.obits = s.obits - w;
          end
        end
        // rest of frame ignored
        D_SKIP: n.st = D_SKIP;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.cs_m <= 1'b1;
      s.cs_s <= 1'b1;
      s.prm <= `PRM_RESET;
    end else begin
      s <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // lines driven only inside a frame, which trails the pin by the sync delay
  always_comb begin
    link.dev_io_o = 4'h0;
    link.dev_io_oe = 4'h0;
    if (s.drv && !s.cs_s) begin
      unique case (lw)
        2'h0: begin
          link.dev_io_o = {2'h0, s.osr[7], 1'h0};
          link.dev_io_oe = 4'h2;
        end
        2'h1: begin
          link.dev_io_o = {2'h0, s.osr[7:6]};
          link.dev_io_oe = 4'h3;
        end
        default: begin
          link.dev_io_o = s.osr[7:4];
          link.dev_io_oe = 4'hF;
        end
      endcase
    end
  end

  assign rd_addr = s.addr;
  assign powered_down = s.pd;

endmodule : flash_dev

// >>> src/flash_cfg.svh
// flash_cfg.svh: constants shared by both ends of the serial flash link
// assumes: a 250 MHz system clock at both ends, link clock sampled by it
// Summary of operation
// - 0Ch quad read wraps inside section
// - wrap length, dummy count from C0h
// - B9h after chip select fall: power-down
// - chip select rise after bit eight only
// - power-down reached within entry time
// - powered down: only ABh recognised
// - power-up always in normal operation
// - ABh release, then hold select high
// - ABh plus three dummies: id repeats
// - release with id needs shorter wait
// - ABh ignored while busy
// - 90h address zero: manufacturer then device
// - address one: device first, alternating
// - 92h header and answer two-bit
// - 94h four-bit plus four dummies
// - 4Bh four dummies, 64-bit unique number
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH

// clock rate and time conversion
`define CLK_MHZ 250
`define NS2CYC_DN(ns) (((ns) * `CLK_MHZ) / 1000 < 1 ? 1 : ((ns) * `CLK_MHZ) / 1000)
`define NS2CYC_UP(ns) (((ns) * `CLK_MHZ + 999) / 1000 < 1 ? 1 : ((ns) * `CLK_MHZ + 999) / 1000)

// instruction codes
`define OP_BURST_WRAP 8'h0C
`define OP_SET_PARAMS 8'hC0
`define OP_POWER_DOWN 8'hB9
`define OP_RELEASE 8'hAB
`define OP_ID_SINGLE 8'h90
`define OP_ID_DUAL 8'h92
`define OP_ID_QUAD 8'h94
`define OP_UNIQUE 8'h4B

// times in ns
`define PD_ENTRY_NS 3000
`define RELEASE_NS 3000
`define RELEASE_ID_NS 1800

// frame field lengths in bits or clocks
`define CMD_BITS 6'h08
`define HDR_ADDR 6'h18
`define HDR_ADDR_MODE 6'h20
`define HDR_RELEASE 6'h18
`define HDR_UNIQUE 6'h20
`define HDR_PRM 6'h08
`define ID_QUAD_DUMMY 6'h04
`define BYTE_BITS 4'h8

// read parameter byte layout and reset value
`define PRM_WRAP_LSB 0
`define PRM_DUMMY_LSB 4
`define PRM_RESET 8'h00
`define WRAP_BASE 24'h000008
`define DUMMY_STEP 6'h02

// host link clock and gaps
`define SCLK_HALF_CYC 20
`define CS_GAP_CYC 16'h0002

`endif

// >>> src/flash_pkg.sv
// flash_pkg.sv: state types of both link ends
// assumes: constants come from flash_cfg.svh
package flash_pkg;
  // device frame progress
  typedef enum logic [2:0] {D_IDLE, D_CMD, D_HDR, D_OUT, D_ARM_PD, D_SKIP} dev_state_e;
  // device timed waits
  typedef enum logic [1:0] {W_NONE, W_ENTRY, W_REL} wait_e;
  // host frame progress
  typedef enum logic [2:0] {H_IDLE, H_CMD, H_HDR, H_DUM, H_RD, H_GAP} host_state_e;
endpackage : flash_pkg

// >>> src/flash_link_if.sv
// flash_link_if.sv: serial flash link between host and device ends
// assumes: lines float high through a pull-up when nobody drives
`timescale 1ns/10ps
interface flash_link_if;
  logic cs_n; // chip select, low in frame
  logic sclk; // serial clock from host
  logic [3:0] host_io_o; // host line values
  logic [3:0] host_io_oe; // host drives line when high
  logic [3:0] dev_io_o; // device line values
  logic [3:0] dev_io_oe; // device drives line when high
  logic [3:0] io; // resolved serial_line_3..serial_line_0
  // resolve lines, device first, else pull-up
  assign io = (dev_io_oe & dev_io_o) | (~dev_io_oe & host_io_oe & host_io_o)
    | (~dev_io_oe & ~host_io_oe);
  modport dev (input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe);
  modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
endinterface : flash_link_if

// >>> src/flash_host.sv
// flash_host.sv: host end, runs one framed command per request
// assumes: the device samples on rising sclk and answers on falling sclk
`timescale 1ns/10ps
`include "flash_cfg.svh"
module flash_host import flash_pkg::*; #(
  parameter int HALF_CYC = `SCLK_HALF_CYC,
  parameter int RELEASE_CYC = `NS2CYC_UP(`RELEASE_NS),
  parameter int RELEASE_ID_CYC = `NS2CYC_UP(`RELEASE_ID_NS)
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // serial link
  flash_link_if.host link,
  // request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_op,
  input wire logic [31:0] req_hdr,
  input wire logic [5:0] req_hdr_clks,
  input wire logic [5:0] req_dummy,
  input wire logic [7:0] req_rd_bytes,
  input wire logic [1:0] req_cmd_lw,
  input wire logic [1:0] req_lw,
  // answer
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic done
);

  // ****************************************
  // parameters and checks
  // ****************************************
  // half period must cover both synchronisers with margin
  if (HALF_CYC < 8 || HALF_CYC > 255 || RELEASE_CYC >= 65536 ||
      RELEASE_ID_CYC >= 65536) begin : g_bad
    $error("flash_host parameter out of range");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    host_state_e st; // frame progress
    logic [7:0] div; // clock divider
    logic sclk; // link clock
    logic cs_n; // chip select
    logic [39:0] tx; // instruction and header
    logic [5:0] cnt; // clocks in phase
    logic [7:0] op; // instruction in flight
    logic [1:0] clw; // command lanes log2
    logic [1:0] lw; // header and answer lanes log2
    logic [5:0] hclks; // header clocks
    logic [5:0] dum; // dummy clocks
    logic [7:0] nrd; // bytes still to read
    logic [7:0] rx; // answer shifter
    logic [3:0] rbits; // bits in rx
    logic [3:0] io_m; // first sync stage
    logic [3:0] io_s; // synced lines
    logic rsp_v; // answer byte pulse
    logic [7:0] rsp_d; // answer byte
    logic dn; // frame done pulse
    logic [15:0] gap; // chip select high time
  } host_s;

  host_s s; // current
  host_s n; // next

  // next phase, skipping empty ones
  function automatic host_state_e nxt(input host_state_e cur, input host_s v);
    if (cur == H_CMD && v.hclks != 6'h0) return H_HDR;
    if ((cur == H_CMD || cur == H_HDR) && v.dum != 6'h0) return H_DUM;
    if (cur != H_RD && v.nrd != 8'h0) return H_RD;
    return H_GAP;
  endfunction : nxt

  // ****************************************
  // next state
  // ****************************************
  logic tick; // half period elapsed
  logic [1:0] cur_lw; // lanes of this phase
  logic [5:0] plen; // clocks of this phase

  always_comb begin
    n = s;
    n.io_m = link.io;
    n.io_s = s.io_m;
    n.rsp_v = 1'b0;
    n.dn = 1'b0;
    tick = (s.div == 8'(HALF_CYC - 1));
    cur_lw = (s.st == H_CMD) ? s.clw : s.lw;
    plen = (s.st == H_CMD) ? (`CMD_BITS >> s.clw) : (s.st == H_HDR) ? s.hclks : s.dum;
    unique case (s.st)
      // take a request, lower chip select, first bit set up
      H_IDLE: if (req_valid) begin
        n.st = H_CMD;
        n.cs_n = 1'b0;
        n.div = 8'h0;
        n.cnt = 6'h0;
        n.tx = {req_op, req_hdr};
        n.op = req_op;
        n.clw = req_cmd_lw;
        n.lw = req_lw;
        n.hclks = req_hdr_clks;
        n.dum = req_dummy;
        n.nrd = req_rd_bytes;
        n.rbits = 4'h0;
      end
      // chip select high for the release or plain gap
      H_GAP: begin
        if (s.gap == 16'h0) n.st = H_IDLE;
        else n.gap = s.gap - 16'h0001;
      end
      // active frame, divider runs
      default: begin
        n.div = tick ? 8'h0 : s.div + 8'h01;
        if (tick) begin
          n.sclk = ~s.sclk;
          if (!s.sclk) begin
            // rising: device answer sampled
            if (s.st == H_RD) begin
              unique case (s.lw)
                2'h0: n.rx = {s.rx[6:0], s.io_s[1]};
                2'h1: n.rx = {s.rx[5:0], s.io_s[1:0]};
                default: n.rx = {s.rx[3:0], s.io_s};
              endcase
              n.rbits = s.rbits + (4'h1 << s.lw);
              if (n.rbits == `BYTE_BITS) begin
                n.rbits = 4'h0;
                n.rsp_v = 1'b1;
                n.rsp_d = n.rx;
                n.nrd = s.nrd - 8'h01;
              end
            end
          end else begin
            // falling: a clock completed, next bits set up
            n.cnt = s.cnt + 6'h01;
            if (s.st == H_CMD || s.st == H_HDR) n.tx = s.tx << (6'h1 << cur_lw);
            if ((s.st == H_RD) ? (s.nrd == 8'h0) : (n.cnt == plen)) begin
              n.cnt = 6'h0;
              n.st = nxt(s.st, s);
              if (n.st == H_GAP) begin
                n.cs_n = 1'b1;
                n.dn = 1'b1;
                n.gap = `CS_GAP_CYC;
                if (s.op == `OP_RELEASE) begin
                  n.gap = (s.hclks != 6'h0) ? 16'(RELEASE_ID_CYC) : 16'(RELEASE_CYC);
                end
              end
            end
          end
        end
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.cs_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // drive only while sending instruction and header
  always_comb begin
    link.host_io_o = 4'h0;
    link.host_io_oe = 4'h0;
    if (s.st == H_CMD || s.st == H_HDR) begin
      unique case (cur_lw)
        2'h0: begin
          link.host_io_o = {3'h0, s.tx[39]};
          link.host_io_oe = 4'h1;
        end
        2'h1: begin
          link.host_io_o = {2'h0, s.tx[39:38]};
          link.host_io_oe = 4'h3;
        end
        default: begin
          link.host_io_o = s.tx[39:36];
          link.host_io_oe = 4'hF;
        end
      endcase
    end
  end

  assign link.cs_n = s.cs_n;
  assign link.sclk = s.sclk;
  assign req_ready = (s.st == H_IDLE);
  assign rsp_valid = s.rsp_v;
  assign rsp_data = s.rsp_d;
  assign done = s.dn;

endmodule : flash_host

// >>> dv/flash_link_assertions.sv
// flash_link_assertions.sv: link rules watched on the wires between both ends
// assumes: the bench ties it to the interface that joins host and device
`timescale 1ns/10ps
module flash_link_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // link lines
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] host_io_o,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe
);
  // ****************************************
  // properties, all in the system clock domain
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // never two drivers on one line
  property p_no_fight; (dev_io_oe & host_io_oe) == 4'h0; endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive a line");
  // device lets go soon after the frame ends
  property p_dev_quiet; $rose(cs_n) |-> ##[1:6] dev_io_oe == 4'h0; endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("device drives after frame");
  // device never starts driving outside a frame
  property p_dev_in_frame; $rose(|dev_io_oe) |-> !cs_n; endproperty
  a_dev_in_frame: assert property (p_dev_in_frame) else $error("device drives off frame");
  // link clock rests low between frames
  property p_sclk_idle; cs_n |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("link clock runs off frame");
  // host bits settled around the rising sample point
  property p_host_hold; $rose(sclk) && |host_io_oe |-> $stable(host_io_o) [*8]; endproperty
  a_host_hold: assert property (p_host_hold) else $error("host bits move at sample");
  // device answer held for eight cycles from each rising edge
  property p_dev_hold; $rose(sclk) && |dev_io_oe |-> $stable(dev_io_o) [*8]; endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("device bits move at sample");
  // high phase long enough for the sampler
  property p_sclk_high; $rose(sclk) |-> sclk [*8]; endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("link clock high too short");
  // low phase long enough for the answer to turn
  property p_sclk_low; $fell(sclk) |-> !sclk [*8]; endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("link clock low too short");
endmodule : flash_link_assertions

// >>> dv/flash_power_down_and_id_commands_test.sv
// flash_power_down_and_id_commands_test.sv: host and device ends run back to back
// assumes: released lines float high, wait counts shortened by parameters
`timescale 1ns/10ps
module flash_power_down_and_id_commands_test import flash_pkg::*;;
  // ****************************************
  // setup
  // ****************************************
  localparam logic [7:0] MFR = 8'h5A; // arbitrary value
  localparam logic [7:0] DID = 8'h17; // arbitrary value
  localparam logic [63:0] UID = 64'hA5C30F1E2D3C4B5A; // arbitrary value
  localparam int PD = 20; // entry wait, shortened
  localparam int REL = 40; // plain release wait
  localparam int RID = 20; // release with id wait, shorter on purpose
  typedef struct {logic [7:0] op; logic [31:0] hdr; logic [5:0] clks; logic [5:0] dum;
    logic [7:0] nb; logic [1:0] clw; logic [1:0] lw; logic qm; logic [23:0] exp;} row_s;
  logic clock, nrst, quad, busy, req_valid, req_ready, rsp_valid, done, powered_down;
  logic [7:0] req_op, req_rd_bytes, rsp_data, rd_data;
  logic [31:0] req_hdr;
  logic [5:0] req_hdr_clks, req_dummy;
  logic [1:0] req_cmd_lw, req_lw;
  logic [23:0] rd_addr;
  logic [7:0] got[$]; // answer bytes of the last frame
  int error_cnt, total_checks;
  // array content equals the low address byte, so wrap shows directly
  assign rd_data = rd_addr[7:0];
  // ordinary frames: request fields beside the bytes they should return
  row_s rows[9] = '{
    '{8'h90, 32'h0, 6'h18, 6'h0, 8'h2, 2'h0, 2'h0, 1'b0, {MFR, DID, 8'h0}},
    '{8'h90, 32'h100, 6'h18, 6'h0, 8'h3, 2'h0, 2'h0, 1'b0, {DID, MFR, DID}},
    '{8'h92, 32'h0, 6'h10, 6'h0, 8'h3, 2'h0, 2'h1, 1'b0, {MFR, DID, MFR}},
    '{8'h94, 32'h100, 6'h08, 6'h4, 8'h3, 2'h0, 2'h2, 1'b0, {DID, MFR, DID}},
    '{8'hAB, 32'h0, 6'h18, 6'h0, 8'h3, 2'h0, 2'h0, 1'b0, {DID, DID, DID}},
    '{8'h4B, 32'h0, 6'h20, 6'h0, 8'h3, 2'h0, 2'h0, 1'b0, UID[63:40]},
    '{8'h0C, 32'h600, 6'h06, 6'h2, 8'h3, 2'h2, 2'h2, 1'b1, 24'h060700},
    '{8'hC0, 32'h11000000, 6'h02, 6'h0, 8'h0, 2'h2, 2'h2, 1'b1, 24'h0},
    '{8'h0C, 32'hE00, 6'h06, 6'h4, 8'h3, 2'h2, 2'h2, 1'b1, 24'h0E0F00}};
  // ****************************************
  // instances
  // ****************************************
  flash_link_if flash_link_if_i ();
  flash_dev #(.MFR_ID(MFR), .DEV_ID(DID), .UNIQUE_ID(UID), .PD_ENTRY_CYC(PD),
    .RELEASE_CYC(REL), .RELEASE_ID_CYC(RID)) flash_dev_i (.clock(clock), .nrst(nrst),
    .link(flash_link_if_i.dev), .quad_command_mode(quad), .busy(busy), .rd_addr(rd_addr),
    .rd_data(rd_data), .powered_down(powered_down));
  flash_host #(.RELEASE_CYC(REL), .RELEASE_ID_CYC(RID)) flash_host_i (.clock(clock),
    .nrst(nrst), .link(flash_link_if_i.host), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_hdr(req_hdr), .req_hdr_clks(req_hdr_clks), .req_dummy(req_dummy),
    .req_rd_bytes(req_rd_bytes), .req_cmd_lw(req_cmd_lw), .req_lw(req_lw),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .done(done));
  flash_link_assertions flash_link_assertions_i (.clock(clock), .nrst(nrst),
    .cs_n(flash_link_if_i.cs_n), .sclk(flash_link_if_i.sclk),
    .host_io_o(flash_link_if_i.host_io_o), .host_io_oe(flash_link_if_i.host_io_oe),
    .dev_io_o(flash_link_if_i.dev_io_o), .dev_io_oe(flash_link_if_i.dev_io_oe));
  // ****************************************
  // tasks
  // ****************************************
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // idle cycles, sampled on falling clock edges
  task automatic waitn(input int k);
    repeat (k) @(negedge clock);
  endtask : waitn
  // one frame: request on rising edges, answers sampled mid-cycle
  task automatic run(input row_s r);
    int n;
    n = 0;
    got.delete();
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    quad <= r.qm;
    req_op <= r.op;
    req_hdr <= r.hdr;
    req_hdr_clks <= r.clks;
    req_dummy <= r.dum;
    req_rd_bytes <= r.nb;
    req_cmd_lw <= r.clw;
    req_lw <= r.lw;
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    // bounded wait, a hung frame counts as a mismatch
    while (done !== 1'b1 && n < 9000) begin
      @(negedge clock);
      n++;
      if (rsp_valid === 1'b1) got.push_back(rsp_data);
    end
    if (n >= 9000) chk(32'h1, 32'h0);
  endtask : run
  // plain single-lane frame with an all-zero header
  task automatic one(input logic [7:0] op, input logic [5:0] clks, input logic [7:0] nb);
    run('{op, 32'h0, clks, 6'h0, nb, 2'h0, 2'h0, 1'b0, 24'h0});
  endtask : one
  // ****************************************
  // clock, watchdog, sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // whole run needs some 18k cycles, this allows over five times that
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end
  initial begin
    {nrst, quad, busy, req_valid, req_op, req_hdr, req_hdr_clks} = '0;
    {req_dummy, req_rd_bytes, req_cmd_lw, req_lw} = '0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    chk(powered_down, 1'b0);
    chk(flash_link_if_i.cs_n, 1'b1);
    $display("reset test done");
    foreach (rows[i]) begin
      run(rows[i]);
      chk(got.size(), rows[i].nb);
      foreach (got[k]) chk(got[k], rows[i].exp[23 - 8 * k -: 8]);
      $display("row %0d done", i);
    end
    // ninth clock after the code cancels entry
    one(8'hB9, 6'h01, 8'h0);
    waitn(PD + 8);
    chk(powered_down, 1'b0);
    one(8'hB9, 6'h0, 8'h0);
    waitn(PD + 8);
    chk(powered_down, 1'b1);
    // powered down: identifier read finds lines released
    one(8'h90, 6'h18, 8'h1);
    chk(got[0], 8'hFF);
    chk(powered_down, 1'b1);
    @(posedge clock);
    busy <= 1'b1;
    one(8'hAB, 6'h0, 8'h0);
    waitn(REL + 8);
    chk(powered_down, 1'b1);
    @(posedge clock);
    busy <= 1'b0;
    // release with identifier uses the shorter wait
    one(8'hAB, 6'h18, 8'h1);
    chk(got[0], DID);
    waitn(RID + 8);
    chk(powered_down, 1'b0);
    one(8'hB9, 6'h0, 8'h0);
    waitn(PD + 8);
    one(8'hAB, 6'h0, 8'h0);
    waitn(RID + 8);
    chk(powered_down, 1'b1);
    waitn(REL - RID);
    chk(powered_down, 1'b0);
    $display("power tests done");
    conclude();
  end
endmodule : flash_power_down_and_id_commands_test
